//--- hw/acs_regs.sv
/*
 Configuration register bank behind the serial control port: staged and
 active copies, self-test signature readback, sync control and the
 divider phase delay / output data clock inversion.
 Assumes serial clock well below ref_clk/8; pins are asynchronous.
*/
`timescale 1ns/100ps
module acs_regs
(
   // clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 rst,
   // serial control port
   input  wire logic                 sclk,
   input  wire logic                 csb_n,
   input  wire logic                 sdio_in,
   output logic                      sdio_out,
   output logic                      sdio_oe_n,
   // self-test engine signature
   input  wire logic [15:0]          selftest_signature,
   // clocking and sync
   input  wire logic                 divider_clk_en,
   input  wire logic                 output_data_clock_in,
   input  wire logic                 sync_in,
   output logic                      divider_clk_en_delayed,
   output logic                      output_data_clock,
   output logic                      divider_resync,
   output logic                      signal_monitor_sync,
   // active configuration
   output acs_pkg::acs_cfg_type      cfg_active
);
   acs_pkg::acs_cfg_type       stage_ff;
   acs_pkg::acs_cfg_type       active_ff;
   acs_pkg::acs_spi_state_type state_ff;
   logic [2:0]  sclk_ff;
   logic [1:0]  csb_ff;
   logic [1:0]  sdi_ff;
   logic [2:0]  syn_ff;
   logic [3:0]  cnt_ff;
   logic [15:0] shift_ff;
   logic [7:0]  tx_ff;
   logic        rd_ff;
   logic [12:0] addr_ff;
   logic [15:0] sig_ff;
   logic [acs_pkg::PHASE_MAX:0] dly_ff;
   logic        odc_ff;
   logic        resync_ff;
   logic        mon_ff;
   logic        sdo_ff;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        sync_rise;
   logic        byte_done;
   logic        wr_en;
   logic        update;
   logic        sync_fire;
   logic [15:0] nxt_shift;

   function automatic logic [7:0] rd_byte(input logic [12:0] a,
                                          input acs_pkg::acs_cfg_type c,
                                          input logic [15:0] s);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         acs_pkg::ADDR_CLK_PHASE:  v = c.clk_phase;
         acs_pkg::ADDR_CLK_DELAY:  v = c.clk_delay;
         acs_pkg::ADDR_REF_SPAN:   v = c.ref_span;
         acs_pkg::ADDR_SIG_LOW:    v = s[7:0];
         acs_pkg::ADDR_SIG_HIGH:   v = s[15:8];
         acs_pkg::ADDR_SYNC:       v = c.sync_ctl;
         acs_pkg::ADDR_DETECT:     v = c.detect_ctl;
         acs_pkg::ADDR_UPPER_LOW:  v = c.upper_thresh[7:0];
         acs_pkg::ADDR_UPPER_HIGH: v = {3'h0, c.upper_thresh[12:8]};
         acs_pkg::ADDR_LOWER_LOW:  v = c.lower_thresh[7:0];
         acs_pkg::ADDR_LOWER_HIGH: v = {3'h0, c.lower_thresh[12:8]};
         default:                  v = 8'h00;
      endcase
      return v;
   endfunction

   // pin synchronisers; first stages feed only second stages
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         sclk_ff <= 3'h7;                    // idles high: no false edge
         csb_ff  <= 2'h3;
         sdi_ff  <= 2'h0;
         syn_ff  <= 3'h0;
      end
      else
      begin
         sclk_ff <= {sclk_ff[1:0], sclk};
         csb_ff  <= {csb_ff[0], csb_n};
         sdi_ff  <= {sdi_ff[0], sdio_in};
         syn_ff  <= {syn_ff[1:0], sync_in};
      end
   end

   assign sclk_rise = sclk_ff[1] & ~sclk_ff[2] & ~csb_ff[1];
   assign sclk_fall = ~sclk_ff[1] & sclk_ff[2] & ~csb_ff[1];
   assign sync_rise = syn_ff[1] & ~syn_ff[2];
   assign nxt_shift = {shift_ff[14:0], sdi_ff[1]};
   assign byte_done = sclk_rise && state_ff == acs_pkg::ST_DATA
                      && cnt_ff == acs_pkg::BYTE_LAST;
   assign wr_en     = byte_done && !rd_ff;
   assign update    = wr_en && addr_ff == acs_pkg::ADDR_UPDATE
                      && nxt_shift[acs_pkg::POS_TRANSFER];

   // serial port framing: 16-bit instruction, then bytes, address counts down
   always_ff @(posedge ref_clk)
   begin
      if (rst || csb_ff[1])
      begin
         state_ff <= acs_pkg::ST_IDLE;
         cnt_ff   <= 4'h0;
         shift_ff <= 16'h0000;
         rd_ff    <= 1'b0;
         addr_ff  <= 13'h0000;
         tx_ff    <= 8'h00;
      end
      else
      begin
         case (state_ff)
            acs_pkg::ST_IDLE:
            begin
               state_ff <= acs_pkg::ST_INSTR;
               cnt_ff   <= 4'h0;
            end
            acs_pkg::ST_INSTR:
            begin
               if (sclk_rise)
               begin
                  shift_ff <= nxt_shift;
                  cnt_ff   <= cnt_ff + 4'h1;
                  if (cnt_ff == acs_pkg::INSTR_LAST)
                  begin
                     state_ff <= acs_pkg::ST_DATA;
                     cnt_ff   <= 4'h0;
                     rd_ff    <= nxt_shift[15];
                     addr_ff  <= nxt_shift[12:0];
                     tx_ff    <= rd_byte(nxt_shift[12:0], stage_ff, sig_ff);
                  end
               end
               else if (sclk_fall && rd_ff)
                  tx_ff <= {tx_ff[6:0], 1'b0};
            end
            acs_pkg::ST_DATA:
            begin
               if (sclk_rise)
               begin
                  shift_ff <= nxt_shift;
                  cnt_ff   <= cnt_ff + 4'h1;
                  if (cnt_ff == acs_pkg::BYTE_LAST)
                  begin
                     cnt_ff  <= 4'h0;
                     addr_ff <= addr_ff - 13'h0001;
                     tx_ff   <= rd_byte(addr_ff - 13'h0001, stage_ff,
                                        sig_ff);
                  end
               end
               else if (sclk_fall)
                  tx_ff <= {tx_ff[6:0], 1'b0};
            end
            default:
               state_ff <= acs_pkg::ST_IDLE;
         endcase
      end
   end

   // read data driven after the falling edge of the serial clock
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         sdo_ff <= 1'b0;
      else if (sclk_fall)
         sdo_ff <= tx_ff[7];
   end
   assign sdio_out  = sdo_ff;
   assign sdio_oe_n = !(rd_ff && state_ff == acs_pkg::ST_DATA && !csb_ff[1]);

   // self-test signature capture
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         sig_ff <= acs_pkg::RST_SIG;
      else
         sig_ff <= selftest_signature;
   end

   // staged copy written over the serial port
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         stage_ff <= acs_pkg::RST_CFG;
      else
      begin
         if (wr_en)
         begin
            case (addr_ff)
               acs_pkg::ADDR_CLK_PHASE:  stage_ff.clk_phase  <= nxt_shift[7:0];
               acs_pkg::ADDR_CLK_DELAY:  stage_ff.clk_delay  <= nxt_shift[7:0];
               acs_pkg::ADDR_REF_SPAN:   stage_ff.ref_span   <= nxt_shift[7:0];
               acs_pkg::ADDR_SYNC:       stage_ff.sync_ctl   <= nxt_shift[7:0];
               acs_pkg::ADDR_DETECT:     stage_ff.detect_ctl <= nxt_shift[7:0];
               acs_pkg::ADDR_UPPER_LOW:
                  stage_ff.upper_thresh[7:0] <= nxt_shift[7:0];
               acs_pkg::ADDR_UPPER_HIGH:
                  stage_ff.upper_thresh[12:8] <= nxt_shift[4:0];
               acs_pkg::ADDR_LOWER_LOW:
                  stage_ff.lower_thresh[7:0] <= nxt_shift[7:0];
               acs_pkg::ADDR_LOWER_HIGH:
                  stage_ff.lower_thresh[12:8] <= nxt_shift[4:0];
               default:
                  stage_ff <= stage_ff;
            endcase
         end
         // one-shot clear is lost only to a write of the sync register itself
         if (sync_fire && stage_ff.sync_ctl[acs_pkg::POS_NEXT_ONLY]
             && !(wr_en && addr_ff == acs_pkg::ADDR_SYNC))
            stage_ff.sync_ctl[acs_pkg::POS_DIV_SYNC] <= 1'b0;
      end
   end

   assign sync_fire = sync_rise && active_ff.sync_ctl[acs_pkg::POS_MASTER]
                      && active_ff.sync_ctl[acs_pkg::POS_DIV_SYNC];

   // active copy; a transfer wins over the one-shot sync clear
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         active_ff <= acs_pkg::RST_CFG;
      else if (update)
         active_ff <= stage_ff;
      else if (sync_fire && active_ff.sync_ctl[acs_pkg::POS_NEXT_ONLY])
         active_ff.sync_ctl[acs_pkg::POS_DIV_SYNC] <= 1'b0;
   end
   assign cfg_active = active_ff;

   // sync pulses
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         resync_ff <= 1'b0;
         mon_ff    <= 1'b0;
      end
      else
      begin
         resync_ff <= sync_fire;
         mon_ff    <= sync_rise && active_ff.sync_ctl[acs_pkg::POS_MASTER]
                      && active_ff.sync_ctl[acs_pkg::POS_MON_SYNC];
      end
   end
   assign divider_resync      = resync_ff;
   assign signal_monitor_sync = mon_ff;

   // divider input delay line and output data clock polarity
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         dly_ff <= '0;
         odc_ff <= 1'b0;
      end
      else
      begin
         dly_ff <= {dly_ff[acs_pkg::PHASE_MAX-1:0], divider_clk_en};
         odc_ff <= output_data_clock_in
                   ^ active_ff.clk_phase[acs_pkg::POS_INVERT];
      end
   end
   assign divider_clk_en_delayed = (active_ff.clk_phase[2:0] == 3'h0)
      ? divider_clk_en : dly_ff[active_ff.clk_phase[2:0] - 3'h1];
   assign output_data_clock = odc_ff;
endmodule

//--- pkg/acs_pkg.sv
/*
 Constants, types and register map for the converter configuration bank.
 Assumes a single ref_clk domain; serial port pins are synchronised in hw.
*/
package acs_pkg;
   localparam logic [12:0] ADDR_CLK_PHASE  = 13'h0016;
   localparam logic [12:0] ADDR_CLK_DELAY  = 13'h0017;
   localparam logic [12:0] ADDR_REF_SPAN   = 13'h0018;
   localparam logic [12:0] ADDR_SIG_LOW    = 13'h0024;
   localparam logic [12:0] ADDR_SIG_HIGH   = 13'h0025;
   localparam logic [12:0] ADDR_UPDATE     = 13'h00ff;
   localparam logic [12:0] ADDR_SYNC       = 13'h0100;
   localparam logic [12:0] ADDR_DETECT     = 13'h0104;
   localparam logic [12:0] ADDR_UPPER_LOW  = 13'h0106;
   localparam logic [12:0] ADDR_UPPER_HIGH = 13'h0107;
   localparam logic [12:0] ADDR_LOWER_LOW  = 13'h0108;
   localparam logic [12:0] ADDR_LOWER_HIGH = 13'h0109;

   localparam logic [7:0] RST_CLK_PHASE = 8'h00;
   localparam logic [7:0] RST_CLK_DELAY = 8'h00;
   localparam logic [7:0] RST_REF_SPAN  = 8'hc0;
   localparam logic [7:0] RST_SYNC      = 8'h00;
   localparam logic [7:0] RST_DETECT    = 8'h00;
   localparam logic [12:0] RST_THRESH   = 13'h0000;
   localparam logic [15:0] RST_SIG      = 16'h0000;

   localparam int POS_INVERT     = 7;
   localparam int POS_SPAN       = 6;
   localparam int POS_MASTER     = 0;
   localparam int POS_DIV_SYNC   = 1;
   localparam int POS_NEXT_ONLY  = 2;
   localparam int POS_MON_SYNC   = 7;
   localparam int POS_TRANSFER   = 0;
   localparam int PHASE_MAX      = 7;

   localparam logic [3:0] INSTR_LAST = 4'hf;
   localparam logic [3:0] BYTE_LAST  = 4'h7;

   typedef enum {ST_IDLE, ST_INSTR, ST_DATA} acs_spi_state_type;

   typedef struct packed {
      logic [7:0]  clk_phase;
      logic [7:0]  clk_delay;
      logic [7:0]  ref_span;
      logic [7:0]  sync_ctl;
      logic [7:0]  detect_ctl;
      logic [12:0] upper_thresh;
      logic [12:0] lower_thresh;
   } acs_cfg_type;

   localparam acs_cfg_type RST_CFG = '{RST_CLK_PHASE, RST_CLK_DELAY,
      RST_REF_SPAN, RST_SYNC, RST_DETECT, RST_THRESH, RST_THRESH};
endpackage

//--- testbench/acs_regs_sva.sv
/* port assertions for the configuration bank.
 assumes the single ref_clk domain of acs_regs. */
`timescale 1ns/100ps
module acs_regs_sva
(
   // clock and reset
   input wire logic                 ref_clk,
   input wire logic                 rst,
   // watched ports
   input wire logic                 csb_n,
   input wire logic                 sdio_oe_n,
   input wire logic                 sync_in,
   input wire logic                 divider_clk_en,
   input wire logic                 output_data_clock_in,
   input wire logic                 divider_clk_en_delayed,
   input wire logic                 output_data_clock,
   input wire logic                 divider_resync,
   input wire logic                 signal_monitor_sync,
   input wire acs_pkg::acs_cfg_type cfg_active
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_reset_state_ok: assert property (disable iff (1'b0) $fell(rst) |->
      cfg_active == acs_pkg::RST_CFG && sdio_oe_n && !divider_resync)
      else $error("state after reset wrong");
   a_dco_invert_follows: assert property (!$past(rst) |->
      output_data_clock == ($past(output_data_clock_in)
      ^ $past(cfg_active.clk_phase[7])))
      else $error("output data clock polarity wrong");
   a_phase_zero_pass: assert property (cfg_active.clk_phase[2:0] == 3'd0
      |-> divider_clk_en_delayed == divider_clk_en)
      else $error("phase code zero adds delay");
   a_phase_one_delay: assert property (cfg_active.clk_phase[2:0] == 3'd1
      && $past(cfg_active.clk_phase[2:0]) == 3'd1
      |-> divider_clk_en_delayed == $past(divider_clk_en))
      else $error("phase code one delay wrong");
   a_phase_five_delay: assert property (cfg_active.clk_phase[2:0] == 3'd5
      && $past(cfg_active.clk_phase[2:0], 5) == 3'd5
      |-> divider_clk_en_delayed == $past(divider_clk_en, 5))
      else $error("phase code five delay wrong");
   a_resync_on_sync: assert property ($rose(sync_in)
      && cfg_active.sync_ctl[0] && cfg_active.sync_ctl[1]
      |-> ##[2:6] divider_resync)
      else $error("divider resync missing");
   a_monitor_on_sync: assert property ($rose(sync_in)
      && cfg_active.sync_ctl[0] && cfg_active.sync_ctl[7]
      |-> ##[2:6] signal_monitor_sync)
      else $error("monitor sync missing");
   a_resync_one_cycle: assert property (divider_resync |=> !divider_resync)
      else $error("resync pulse too long");
   a_monitor_one_cycle: assert property (signal_monitor_sync
      |=> !signal_monitor_sync)
      else $error("monitor pulse too long");
   a_active_in_frame: assert property ($changed(cfg_active.upper_thresh)
      || $changed(cfg_active.ref_span) |-> !csb_n)
      else $error("active copy changed outside a frame");
   c_resync: cover property (divider_resync);
   c_monitor: cover property (signal_monitor_sync);
   c_update: cover property ($changed(cfg_active.upper_thresh));
   c_phase_five: cover property (cfg_active.clk_phase[2:0] == 3'd5);
endmodule
bind acs_regs acs_regs_sva u_sva (.ref_clk, .rst, .csb_n, .sdio_oe_n,
   .sync_in, .divider_clk_en, .output_data_clock_in,
   .divider_clk_en_delayed, .output_data_clock, .divider_resync,
   .signal_monitor_sync, .cfg_active);

//--- testbench/testbench.sv
/* self-checking bench for the configuration bank.
 drives the serial port pins directly at the falling edge. */
`timescale 1ns/100ps
module testbench;
   logic ref_clk = 0, rst = 1, sclk = 1, csb_n = 1, sdio_in = 0;
   logic sync_in = 0, divider_clk_en = 0, output_data_clock_in = 0;
   logic [15:0] selftest_signature = 16'h0000;
   logic sdio_out, sdio_oe_n, divider_clk_en_delayed, output_data_clock;
   logic divider_resync, signal_monitor_sync;
   acs_pkg::acs_cfg_type cfg_active;
   int fail_count = 0, check_count = 0, cyc = 0;
   acs_regs uut (.ref_clk, .rst, .sclk, .csb_n, .sdio_in, .sdio_out,
      .sdio_oe_n, .selftest_signature, .divider_clk_en,
      .output_data_clock_in, .sync_in, .divider_clk_en_delayed,
      .output_data_clock, .divider_resync, .signal_monitor_sync,
      .cfg_active);
   initial forever #50 ref_clk = ~ref_clk;
   always @(negedge ref_clk)
      {divider_clk_en, output_data_clock_in} <= cyc[1:0] ^ cyc[4:3];
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         close_out();
      end
   end
   task close_out();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // one frame: instruction then one data byte, sclk half period 5 cycles
   task spi(input logic r, input logic [12:0] a, input logic [7:0] w,
      output logic [7:0] q);
      logic [23:0] f;
      f = {r, 2'b00, a, w};
      csb_n = 0;
      for (int i = 23; i >= 0; i--)
      begin
         sclk = 0;
         sdio_in = f[i];
         repeat (5) @(negedge ref_clk);
         if (i < 8)
            q[i] = sdio_out;
         if (r && i < 8)
            chk("read drive", 1'b0, sdio_oe_n);
         sclk = 1;
         repeat (5) @(negedge ref_clk);
      end
      csb_n = 1;
      repeat (5) @(negedge ref_clk);
   endtask
   task wr(input logic [12:0] a, input logic [7:0] d);
      logic [7:0] q;
      spi(1'b0, a, d, q);
   endtask
   task rdchk(input string n, input logic [12:0] a, input logic [7:0] e);
      logic [7:0] q;
      spi(1'b1, a, 8'h00, q);
      chk(n, e, q);
   endtask
   task pulse(output logic r, output logic m);
      r = 0;
      m = 0;
      sync_in = 1;
      for (int i = 0; i < 12; i++)
      begin
         @(negedge ref_clk);
         r = r | divider_resync;
         m = m | signal_monitor_sync;
      end
      sync_in = 0;
      repeat (8) @(negedge ref_clk);
   endtask
   task t_reset();
      chk("span", 8'hc0, cfg_active.ref_span);
      chk("sync", 8'h00, cfg_active.sync_ctl);
      chk("detect", 8'h00, cfg_active.detect_ctl);
      chk("lower", 13'h0000, cfg_active.lower_thresh);
      rdchk("sig high", acs_pkg::ADDR_SIG_HIGH, 8'h00);
   endtask
   task t_regs();
      selftest_signature = 16'h5a3c;
      rdchk("sig low", acs_pkg::ADDR_SIG_LOW, 8'h3c);
      wr(acs_pkg::ADDR_SIG_HIGH, 8'hff);
      rdchk("sig high", acs_pkg::ADDR_SIG_HIGH, 8'h5a);
      rdchk("unmapped", 13'h0050, 8'h00);
      for (int i = 0; i < 3; i++)
      begin
         wr(acs_pkg::ADDR_REF_SPAN, 8'(i << 6));
         rdchk("span code", acs_pkg::ADDR_REF_SPAN, 8'(i << 6));
      end
   endtask
   task t_stage();
      wr(acs_pkg::ADDR_UPPER_LOW, 8'hff);
      wr(acs_pkg::ADDR_UPPER_HIGH, 8'hff);
      chk("staged upper", 13'h0000, cfg_active.upper_thresh);
      rdchk("upper high", acs_pkg::ADDR_UPPER_HIGH, 8'h1f);
      wr(acs_pkg::ADDR_LOWER_LOW, 8'h34);
      wr(acs_pkg::ADDR_LOWER_HIGH, 8'h12);
      wr(acs_pkg::ADDR_DETECT, 8'h0f);
      wr(acs_pkg::ADDR_CLK_PHASE, 8'h81);
      wr(acs_pkg::ADDR_UPDATE, 8'h01);
      chk("upper", 13'h1fff, cfg_active.upper_thresh);
      chk("lower", 13'h1234, cfg_active.lower_thresh);
      chk("detect", 8'h0f, cfg_active.detect_ctl);
      chk("span", 8'h80, cfg_active.ref_span);
   endtask
   task t_phase();
      wr(acs_pkg::ADDR_CLK_PHASE, 8'h05);
      wr(acs_pkg::ADDR_UPDATE, 8'h01);
      chk("phase", 8'h05, cfg_active.clk_phase);
      repeat (20) @(negedge ref_clk);
   endtask
   task t_sync();
      logic r, m;
      wr(acs_pkg::ADDR_SYNC, 8'h03);
      wr(acs_pkg::ADDR_UPDATE, 8'h01);
      pulse(r, m);
      chk("resync", 1'b1, r);
      chk("monitor", 1'b0, m);
      wr(acs_pkg::ADDR_SYNC, 8'h87);
      wr(acs_pkg::ADDR_UPDATE, 8'h01);
      pulse(r, m);
      chk("monitor", 1'b1, m);
      chk("resync", 1'b1, r);
      chk("one shot", 8'h85, cfg_active.sync_ctl);
      rdchk("one shot", acs_pkg::ADDR_SYNC, 8'h85);
      pulse(r, m);
      chk("no resync", 1'b0, r);
   endtask
   initial
   begin
      repeat (3) @(negedge ref_clk);
      rst = 0;
      repeat (3) @(negedge ref_clk);
      t_reset();
      t_regs();
      t_stage();
      t_phase();
      t_sync();
      close_out();
   end
endmodule
